/* File: shutdown_detect.sv */
// Top of the five-channel shutdown input detector with its APB register file.
//
// Overview of operation
// (R1) Four-bit detection mode field, bits three..zero.
// (R2) Mode zero: request on falling pin edge.
// (R3) Mode one: sample at clock divided eight.
// (R4) Mode two: sample at clock divided sixteen.
// (R5) Mode three: sample at clock divided 128.
// (R6) Mode four: sample every clock cycle.
// (R7) Mode five: sample every second cycle.
// (R8) Mode six: sample every fourth cycle.
// (R9) Request after required consecutive low samples.
// (R10) Software writes only mode codes zero to six.
// (R11) Separate four-bit sample count field per channel.
// (R12) Each channel has independent settings.
// (R13) Count selects four, eight or sixteen samples.
// (R14) Accepted requests go to output-disable logic.
// (R15) Counter clears on high sample or setting change.
// (R16) One free-running prescaler, zero at reset.
`timescale 1ns/100ps
module shutdown_detect
    import shutdown_detect_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        shutdown_pin_0,
    input  wire logic        shutdown_pin_4,
    input  wire logic        shutdown_pin_8,
    input  wire logic        shutdown_pin_10,
    input  wire logic        shutdown_pin_11,
    output logic [4:0]       disable_request,
    output logic             irq
);

    // ==========================================================
    // State
    // ==========================================================
    typedef struct packed
    {
        logic [NUM_CH-1:0][15:0] ctrl;
        logic [4:0]              status;
        logic [4:0]              mask;
        logic [4:0]              sync1;
        logic [4:0]              sync2;
        logic [4:0]              sync3;
        logic [4:0]              level;
        logic [PRESCALE_W-1:0]   prescale;
        logic [31:0]             rdata;
        logic [4:0]              req_out;
    } top_t;

    top_t r_reg;
    top_t r_next;

    logic [4:0]  pins;
    logic [4:0]  chan_req;
    logic [4:0]  cfg_changed;
    logic [5:0]  tick;
    logic        wr_en;
    logic        rd_en;
    logic        addr_ok;

    assign pins = {shutdown_pin_11, shutdown_pin_10, shutdown_pin_8,
                   shutdown_pin_4, shutdown_pin_0};

    // Map a byte offset to a channel index; returns NUM_CH when not a channel.
    function automatic logic [2:0] chan_of(input logic [11:0] a);
        case (a)
            OFS_CTRL_CH0:  chan_of = 3'h0;
            OFS_CTRL_CH4:  chan_of = 3'h1;
            OFS_CTRL_CH8:  chan_of = 3'h2;
            OFS_CTRL_CH10: chan_of = 3'h3;
            OFS_CTRL_CH11: chan_of = 3'h4;
            default:       chan_of = 3'h5;
        endcase
    endfunction : chan_of

    // Merge write data into a 16-bit register under the byte strobes.
    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] d,
                                            input logic [3:0]  s);
        merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction : merge16

    // ==========================================================
    // APB decode: zero wait states, error on unmapped offsets
    // ==========================================================
    assign addr_ok = (chan_of(paddr) != 3'h5) || paddr == OFS_IRQ_STAT ||
                     paddr == OFS_IRQ_MASK || paddr == OFS_PIN_STAT;
    assign wr_en   = psel && penable && pwrite && addr_ok;
    assign rd_en   = psel && !penable && !pwrite;
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !addr_ok;

    // Prescaler ticks: one-cycle enables at divide 1, 2, 4, 8, 16, 128.
    always_comb
    begin
        tick[0] = 1'b1;                                 // R6
        tick[1] = r_reg.prescale[0] == 1'b1;            // R7
        tick[2] = r_reg.prescale[1:0] == 2'h3;          // R8
        tick[3] = r_reg.prescale[2:0] == 3'h7;          // R3
        tick[4] = r_reg.prescale[3:0] == 4'hF;          // R4
        tick[5] = r_reg.prescale == 7'h7F;              // R5
    end

    // Settings change detect per channel.
    always_comb
    begin
        for (int i = 0; i < NUM_CH; i++)
        begin
            cfg_changed[i] = wr_en && chan_of(paddr) == 3'(i) &&
                (merge16(r_reg.ctrl[i], pwdata, pstrb) != r_reg.ctrl[i]); // R15
        end
    end

    // Next state for registers, synchronisers and prescaler.
    always_comb
    begin
        r_next          = r_reg;
        r_next.sync1    = pins;
        r_next.sync2    = r_reg.sync1;
        r_next.sync3    = r_reg.sync2;
        r_next.prescale = r_reg.prescale + 7'h01; // R16
        r_next.req_out  = chan_req;               // R14
        // A level counts once the second and third stages agree.
        for (int i = 0; i < NUM_CH; i++)
        begin
            if (r_reg.sync2[i] == r_reg.sync3[i])
            begin
                r_next.level[i] = r_reg.sync3[i];
            end
        end
        if (wr_en)
        begin
            if (chan_of(paddr) != 3'h5)
            begin
                r_next.ctrl[chan_of(paddr)] = merge16(r_reg.ctrl[chan_of(paddr)],
                                                      pwdata, pstrb); // R12
            end
            if (paddr == OFS_IRQ_STAT && pstrb[0])
            begin
                r_next.status = r_reg.status & ~pwdata[4:0];
            end
            if (paddr == OFS_IRQ_MASK && pstrb[0])
            begin
                r_next.mask = pwdata[4:0];
            end
        end
        // Set wins over a simultaneous write-one clear.
        r_next.status = r_next.status | chan_req;
        if (rd_en)
        begin
            case (paddr)
                OFS_IRQ_STAT: r_next.rdata = {27'h0, r_reg.status};
                OFS_IRQ_MASK: r_next.rdata = {27'h0, r_reg.mask};
                OFS_PIN_STAT: r_next.rdata = {27'h0, r_reg.level};
                default:
                begin
                    if (chan_of(paddr) != 3'h5)
                    begin
                        r_next.rdata = {16'h0, r_reg.ctrl[chan_of(paddr)]};
                    end
                    else
                    begin
                        r_next.rdata = 32'h0000_0000;
                    end
                end
            endcase
        end
    end

    // Register the whole state.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            r_reg          <= '0;
            r_reg.ctrl     <= {NUM_CH{CTRL_RESET}};
            r_reg.mask     <= MASK_RESET;
            r_reg.sync1    <= 5'h1F;
            r_reg.sync2    <= 5'h1F;
            r_reg.sync3    <= 5'h1F;
            r_reg.level    <= 5'h1F;
        end
        else
        begin
            r_reg <= r_next;
        end
    end

    // ==========================================================
    // Channels
    // ==========================================================
    for (genvar g = 0; g < NUM_CH; g++)
    begin : g_ch
        shutdown_channel u_ch
        (
            .pclk         (pclk),
            .presetn      (presetn),
            .pin_level    (r_reg.level[g]),
            .detect_mode  (r_reg.ctrl[g][MODE_LSB +: MODE_W]),     // R1
            .sample_count (r_reg.ctrl[g][COUNT_LSB +: COUNT_W]),   // R11
            .cfg_changed  (cfg_changed[g]),
            .tick         (tick),
            .request      (chan_req[g])
        );
    end

    // Outputs.
    assign prdata          = r_reg.rdata;
    assign disable_request = r_reg.req_out;
    assign irq             = |(r_reg.status & r_reg.mask);

    // ==========================================================
    // Assertions
    // ==========================================================
    property p_req_forward;
        @(posedge pclk) disable iff (!presetn)
        chan_req[0] |=> disable_request[0];
    endproperty
    a_req_forward: assert property (p_req_forward) else $error("request not passed"); // R14

    property p_status_set;
        @(posedge pclk) disable iff (!presetn)
        chan_req[2] |=> r_reg.status[2];
    endproperty
    a_status_set: assert property (p_status_set) else $error("status bit lost"); // R14

    property p_irq_level;
        @(posedge pclk) disable iff (!presetn)
        chan_req[0] && r_reg.mask[0] && !(wr_en && paddr == OFS_IRQ_MASK) |=> irq;
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("irq mismatch");

    property p_prescale_run;
        @(posedge pclk) disable iff (!presetn)
        $past(presetn) |-> r_reg.prescale == $past(r_reg.prescale) + 7'h01;
    endproperty
    a_prescale_run: assert property (p_prescale_run) else $error("prescaler stalled"); // R16

    property p_div128;
        @(posedge pclk) disable iff (!presetn)
        tick[5] |-> ##1 !tick[5] [*8];
    endproperty
    a_div128: assert property (p_div128) else $error("div128 tick too close"); // R5

    property p_div4;
        @(posedge pclk) disable iff (!presetn)
        tick[2] |=> !tick[2] ##1 !tick[2] ##1 !tick[2] ##1 tick[2];
    endproperty
    a_div4: assert property (p_div4) else $error("div4 tick period"); // R8

    property p_mode_legal;
        @(posedge pclk) disable iff (!presetn)
        r_reg.ctrl[0][3:0] <= MODE_DIV4 && r_reg.ctrl[1][3:0] <= MODE_DIV4 &&
        r_reg.ctrl[2][3:0] <= MODE_DIV4 && r_reg.ctrl[3][3:0] <= MODE_DIV4 &&
        r_reg.ctrl[4][3:0] <= MODE_DIV4;
    endproperty
    a_mode_legal: assert property (p_mode_legal) else $error("illegal mode code"); // R10

    property p_ctrl_indep;
        @(posedge pclk) disable iff (!presetn)
        wr_en && paddr == OFS_CTRL_CH0 |=> $stable(r_reg.ctrl[1]);
    endproperty
    a_ctrl_indep: assert property (p_ctrl_indep) else $error("channel cross write"); // R12

    c_irq: cover property (@(posedge pclk) disable iff (!presetn) irq);
    c_clear_set: cover property (@(posedge pclk) disable iff (!presetn)
        wr_en && paddr == OFS_IRQ_STAT && (chan_req != 5'h00));
    c_unmapped: cover property (@(posedge pclk) disable iff (!presetn) pslverr);

endmodule : shutdown_detect

/* File: shutdown_detect_pkg.sv */
// Package of constants and types for the shutdown input detector.
package shutdown_detect_pkg;

    // ==========================================================
    // Sizes
    // ==========================================================
    localparam int NUM_CH     = 5;
    localparam int MODE_W     = 4;
    localparam int COUNT_W    = 4;
    localparam int PRESCALE_W = 7;

    // ==========================================================
    // Detection mode codes
    // ==========================================================
    localparam logic [3:0] MODE_EDGE     = 4'h0;
    localparam logic [3:0] MODE_DIV8     = 4'h1;
    localparam logic [3:0] MODE_DIV16    = 4'h2;
    localparam logic [3:0] MODE_DIV128   = 4'h3;
    localparam logic [3:0] MODE_DIV1     = 4'h4;
    localparam logic [3:0] MODE_DIV2     = 4'h5;
    localparam logic [3:0] MODE_DIV4     = 4'h6;

    // ==========================================================
    // Sample count codes and runs
    // ==========================================================
    localparam logic [3:0] COUNT_SEL_4  = 4'h0;
    localparam logic [3:0] COUNT_SEL_8  = 4'h1;
    localparam logic [4:0] RUN_4        = 5'h04;
    localparam logic [4:0] RUN_8        = 5'h08;
    localparam logic [4:0] RUN_16       = 5'h10;

    // ==========================================================
    // Register map (byte offsets) and field positions
    // ==========================================================
    localparam logic [11:0] OFS_CTRL_CH0  = 12'h000;
    localparam logic [11:0] OFS_CTRL_CH4  = 12'h004;
    localparam logic [11:0] OFS_CTRL_CH8  = 12'h008;
    localparam logic [11:0] OFS_CTRL_CH10 = 12'h00C;
    localparam logic [11:0] OFS_CTRL_CH11 = 12'h010;
    localparam logic [11:0] OFS_IRQ_STAT  = 12'h014;
    localparam logic [11:0] OFS_IRQ_MASK  = 12'h018;
    localparam logic [11:0] OFS_PIN_STAT  = 12'h01C;
    localparam int MODE_LSB  = 0;
    localparam int COUNT_LSB = 8;
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    localparam logic [4:0]  MASK_RESET = 5'h00;

    // ==========================================================
    // Input filter state machine
    // ==========================================================
    typedef enum logic [2:0]
    {
        ST_IDLE   = 3'b001,
        ST_COUNT  = 3'b010,
        ST_HELD   = 3'b100
    } chan_state_t;

endpackage : shutdown_detect_pkg

/* File: shutdown_channel.sv */
// One shutdown pin qualifier channel: edge or consecutive low sample detection.
`timescale 1ns/100ps
module shutdown_channel
    import shutdown_detect_pkg::*;
(
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire logic               pin_level,
    input  wire logic [MODE_W-1:0]  detect_mode,
    input  wire logic [COUNT_W-1:0] sample_count,
    input  wire logic               cfg_changed,
    input  wire logic [5:0]         tick,
    output logic                    request
);

    // ==========================================================
    // State
    // ==========================================================
    typedef struct packed
    {
        chan_state_t state;
        logic        last_level;
        logic [4:0]  run;
        logic        request;
    } chan_t;

    chan_t s_reg;
    chan_t s_next;

    // Required run length from the count code.
    function automatic logic [4:0] run_len(input logic [3:0] sel);
        case (sel)
            COUNT_SEL_4: run_len = RUN_4;
            COUNT_SEL_8: run_len = RUN_8;
            default:     run_len = RUN_16;
        endcase
    endfunction : run_len

    logic sample_en;

    // Sampling tick picked by the mode code.
    always_comb
    begin
        case (detect_mode)
            MODE_DIV8:   sample_en = tick[3]; // R3
            MODE_DIV16:  sample_en = tick[4]; // R4
            MODE_DIV128: sample_en = tick[5]; // R5
            MODE_DIV1:   sample_en = tick[0]; // R6
            MODE_DIV2:   sample_en = tick[1]; // R7
            MODE_DIV4:   sample_en = tick[2]; // R8
            default:     sample_en = 1'b0;
        endcase
    end

    // Next state: edge detect or counting of consecutive low samples.
    always_comb
    begin
        s_next            = s_reg;
        s_next.request    = 1'b0;
        s_next.last_level = pin_level;
        if (cfg_changed)
        begin
            s_next.run   = 5'h00; // R15
            s_next.state = ST_IDLE;
        end
        else if (detect_mode == MODE_EDGE)
        begin
            s_next.request = s_reg.last_level && !pin_level; // R2
        end
        else if (sample_en)
        begin
            if (pin_level)
            begin
                s_next.run   = 5'h00; // R15
                s_next.state = ST_IDLE;
            end
            else
            begin
                case (s_reg.state)
                    ST_IDLE, ST_COUNT:
                    begin
                        if (s_reg.run + 5'h01 >= run_len(sample_count)) // R9 R13
                        begin
                            s_next.request = 1'b1;
                            s_next.state   = ST_HELD;
                            s_next.run     = 5'h00;
                        end
                        else
                        begin
                            s_next.run   = s_reg.run + 5'h01;
                            s_next.state = ST_COUNT;
                        end
                    end
                    ST_HELD: s_next.state = ST_HELD;
                    default: s_next.state = ST_IDLE;
                endcase
            end
        end
    end

    // State register.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s_reg <= '{state: ST_IDLE, last_level: 1'b1, run: 5'h00, request: 1'b0};
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    assign request = s_reg.request;

    // ==========================================================
    // Assertions
    // ==========================================================
    property p_edge_request;
        @(posedge pclk) disable iff (!presetn)
        (detect_mode == MODE_EDGE && !cfg_changed && s_reg.last_level && !pin_level)
            |=> request;
    endproperty
    a_edge_request: assert property (p_edge_request) else $error("edge lost"); // R2

    property p_high_clears;
        @(posedge pclk) disable iff (!presetn)
        (sample_en && pin_level && !cfg_changed && detect_mode != MODE_EDGE)
            |=> (s_reg.run == 5'h00 && !request);
    endproperty
    a_high_clears: assert property (p_high_clears) else $error("run not cleared"); // R15

    property p_run_bound;
        @(posedge pclk) disable iff (!presetn)
        s_reg.run < run_len(sample_count) || cfg_changed || $changed(sample_count);
    endproperty
    a_run_bound: assert property (p_run_bound) else $error("run exceeds limit"); // R9

    property p_cfg_reset;
        @(posedge pclk) disable iff (!presetn)
        cfg_changed |=> (s_reg.run == 5'h00 && !request);
    endproperty
    a_cfg_reset: assert property (p_cfg_reset) else $error("config change not reset"); // R15

    c_sample_request: cover property (@(posedge pclk) disable iff (!presetn)
        request && detect_mode != MODE_EDGE);
    c_edge_request: cover property (@(posedge pclk) disable iff (!presetn)
        request && detect_mode == MODE_EDGE);

endmodule : shutdown_channel

/* File: shutdown_pin_model.sv */
// Behavioural model of the five external active-low shutdown request pins.
`timescale 1ns/100ps
module shutdown_pin_model
(
    output logic [4:0] pins
);
    // ==========================================================
    // Pin drivers
    // ==========================================================
    // The lines are pulled up, so every pin idles high with no request.
    initial pins = 5'h1F;

    // Drives one pin; callers enter right after a rising edge.
    task automatic drive(input int ch, input logic v);
        pins[ch] <= v;
    endtask : drive
endmodule : shutdown_pin_model

/* File: shutdown_detect_tb.sv */
// Self-checking testbench for the five-channel shutdown input detector.
`timescale 1ns/100ps
module shutdown_detect_tb;
    import shutdown_detect_pkg::*;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [4:0]  pins;
    logic [4:0]  disable_request;
    logic        irq;
    logic [31:0] rd;
    logic        err;
    logic [4:0]  mask_v;
    int          n_errors;
    int          num_checks;
    logic [11:0] ofs [5] = '{OFS_CTRL_CH0, OFS_CTRL_CH4, OFS_CTRL_CH8, OFS_CTRL_CH10,
                             OFS_CTRL_CH11};
    int          divs [7] = '{1, 8, 16, 128, 1, 2, 4};

    // ==========================================================
    // Design, pin model and clock
    // ==========================================================
    shutdown_detect uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .shutdown_pin_0(pins[0]), .shutdown_pin_4(pins[1]), .shutdown_pin_8(pins[2]),
        .shutdown_pin_10(pins[3]), .shutdown_pin_11(pins[4]),
        .disable_request(disable_request), .irq(irq)
    );
    shutdown_pin_model pins_m (.pins(pins));

    // Free-running 100 MHz clock.
    initial pclk = 1'b0;
    always #5 pclk = ~pclk;

    // ==========================================================
    // Shared tasks
    // ==========================================================
    // Prints the counts and the verdict, then ends the run.
    task automatic conclude();
        $display("Checks %0d, mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : conclude

    // Compares one value and counts the result.
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // Compares a measured cycle count against a window.
    task automatic check_range(input string what, input int lo, input int hi, input int got);
        num_checks++;
        if (got < lo || got > hi)
        begin
            n_errors++;
            $display("[ERR] %s expected %0d..%0d seen %0d", what, lo, hi, got);
        end
    endtask : check_range

    // One APB transfer; holds the request until pready is seen high.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        check_range("apb wait", 1, 49, n);
        if (n >= 50)
            conclude();
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    // Waits for a request pulse on one channel and checks its timing.
    task automatic expect_req(input int ch, input int lo, input int hi);
        int n;
        n = 0;
        do
        begin
            @(negedge pclk);
            n++;
        end
        while (disable_request[ch] !== 1'b1 && n <= hi);
        check_range("request delay", lo, hi, n);
        if (n > hi)
            conclude();
        check("other requests", 32'h0, {27'h0, disable_request & ~(5'h01 << ch)});
        @(negedge pclk);
        check("request width", 32'h0, {31'h0, disable_request[ch]});
        @(posedge pclk);
    endtask : expect_req

    // Configures a channel, asserts its pin and checks request, status and irq.
    task automatic run(input int ch, input logic [3:0] mode, input logic [3:0] cs);
        int ns;
        int dv;
        ns = (cs == COUNT_SEL_4) ? 4 : (cs == COUNT_SEL_8) ? 8 : 16;
        dv = divs[mode];
        apb(1'b1, ofs[ch], {16'h0, 4'h0, cs, 4'h0, mode});
        pins_m.drive(ch, 1'b0);
        if (mode == MODE_EDGE)
            expect_req(ch, 3, 8);
        else
            expect_req(ch, (ns - 1) * dv + 3, ns * dv + 8);
        pins_m.drive(ch, 1'b1);
        repeat (dv + 8) @(posedge pclk);
        apb(1'b0, OFS_IRQ_STAT, 32'h0);
        check("status", 32'h1 << ch, rd);
        check("irq", {31'h0, mask_v[ch]}, {31'h0, irq});
        apb(1'b1, OFS_IRQ_STAT, 32'h1F);
        check("irq clear", 32'h0, {31'h0, irq});
        $display("Test done: channel %0d mode %0d count %0d", ch, mode, cs);
    endtask : run

    // ==========================================================
    // Main sequence
    // ==========================================================
    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pstrb = 4'hF;
        n_errors = 0;
        num_checks = 0;
        mask_v = 5'h15;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i < NUM_CH; i++)
        begin
            apb(1'b0, ofs[i], 32'h0);
            check("ctrl reset", {16'h0, CTRL_RESET}, rd);
        end
        apb(1'b0, OFS_IRQ_MASK, 32'h0);
        check("mask reset", {27'h0, MASK_RESET}, rd);
        apb(1'b0, OFS_PIN_STAT, 32'h0);
        check("pin levels", 32'h1F, rd);
        apb(1'b0, 12'h020, 32'h0);
        check("unmapped error", 32'h1, {31'h0, err});
        $display("Test done: reset values");
        apb(1'b1, OFS_IRQ_MASK, {27'h0, mask_v});
        for (int i = 0; i < NUM_CH; i++)
            run(i, MODE_EDGE, COUNT_SEL_4);
        for (int m = 1; m <= 6; m++)
            run(m % NUM_CH, m[3:0], COUNT_SEL_4);
        for (int c = 0; c < 3; c++)
            run(3, MODE_DIV1, c[3:0]);
        apb(1'b1, ofs[1], {16'h0, 4'h0, 4'h2, 4'h0, MODE_DIV1});
        pins_m.drive(1, 1'b0);
        repeat (10) @(posedge pclk);
        pins_m.drive(1, 1'b1);
        repeat (4) @(posedge pclk);
        pins_m.drive(1, 1'b0);
        repeat (10) @(posedge pclk);
        pins_m.drive(1, 1'b1);
        repeat (20) @(posedge pclk);
        apb(1'b0, OFS_IRQ_STAT, 32'h0);
        check("short low run", 32'h0, rd);
        $display("Test done: interrupted low run");
        conclude();
    end
endmodule : shutdown_detect_tb
